/* File: core/psrc_dev.sv */
/*
 Sensor end: power mode, data-ready gating, temperature control,
 self-test enables, software reset and readable factory shadow words.
 Assumes the link interface on pclk and a combinational trim array.
*/
// The APB register port was chosen for this implementation.
// Behaviour
// - Suppress bit forces data-ready output low
// - Temperature disable bit stops temperature processing
// - Standby also stops temperature processing
// - Bit 0 selects standby, resets to one
// - Standby halts temperature and acceleration datapaths
// - Entering standby clears digital state, FIFO pointers
// - Host configures only while in standby; the device gates only the data rate, other fields are taken in any mode
// - High-pass setting may change while measuring
// - Self-test bit 1 enables force, resets zero
// - Self-test bit 0 enables self-test mode
// - Code 0x52 to reset register resets device
// - After any reset, trim loads into shadows
// - Trim load is not always correct
// - Host saves five shadows before software reset
// - Host re-resets until shadows match saved copy; controller gives up and flags fail after MAX_TRIES resets
`timescale 1ns/1ps
`include "psrc_params.svh"
module psrc_dev #(
   parameter logic [7:0] REVISION = 8'h0a
) (
   input wire logic pclk,
   input wire logic presetn,
   psrc_if.dev lnk,
   input wire logic sample_valid,
   output logic data_ready_output,
   output logic temp_run,
   output logic accel_run,
   output logic digital_clear,
   output logic diag_mode_enable,
   output logic diag_force_enable,
   output logic [2:0] hpf_setting,
   output logic [3:0] odr_setting,
   output logic shadow_loading,
   output logic [2:0] nvm_addr,
   input wire logic [7:0] nvm_data
);
   // REVISION default is an arbitrary value

   logic ack_q;
   logic [7:0] rdata_q;
   logic soft_rst_q;
   logic standby_q;
   logic temp_off_q;
   logic data_ready_output_suppress_q;
   logic diag_mode_q;
   logic diag_force_q;
   logic [2:0] hpf_q;
   logic [3:0] odr_q;
   logic data_ready_output_q;
   logic clear_q;
   logic take;
   logic wr;
   logic [2:0] sh_idx;
   logic [7:0] sh_data;
   logic [7:0] rd_d;

   assign take = lnk.req && !ack_q;
   assign wr = take && lnk.we;
   assign sh_idx = 3'(lnk.addr - `PSRC_REG_SHADOW_FIRST);

   psrc_shadow #(
      .COUNT(`PSRC_SHADOW_COUNT)
   ) u_shadow (
      .pclk(pclk),
      .presetn(presetn),
      .restart(soft_rst_q),
      .nvm_addr(nvm_addr),
      .nvm_data(nvm_data),
      .loading(shadow_loading),
      .rd_idx(sh_idx),
      .rd_data(sh_data)
   );

   // Link answer one cycle after a request is taken
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= take;
      end
   end

   // Soft reset pulse; only the exact code acts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= wr && lnk.addr == `PSRC_REG_SWRST
            && lnk.wdata == `PSRC_SWRST_CODE;
      end
   end

   // Power control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         standby_q <= 1'(`PSRC_POWER_RST >> `PSRC_PWR_STANDBY);
         temp_off_q <= 1'b0;
         data_ready_output_suppress_q <= 1'b0;
      end else if (soft_rst_q) begin
         standby_q <= 1'b1;
         temp_off_q <= 1'b0;
         data_ready_output_suppress_q <= 1'b0;
      end else if (wr && lnk.addr == `PSRC_REG_POWER) begin
         standby_q <= lnk.wdata[`PSRC_PWR_STANDBY];
         temp_off_q <= lnk.wdata[`PSRC_PWR_TEMP_OFF];
         data_ready_output_suppress_q <= lnk.wdata[`PSRC_PWR_DATA_READY_OUTPUT_SUPPRESS];
      end
   end

   // Self-test register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         diag_mode_q <= 1'b0;
         diag_force_q <= 1'b0;
      end else if (soft_rst_q) begin
         diag_mode_q <= 1'b0;
         diag_force_q <= 1'b0;
      end else if (wr && lnk.addr == `PSRC_REG_DIAG) begin
         diag_mode_q <= lnk.wdata[`PSRC_DIAG_MODE];
         diag_force_q <= lnk.wdata[`PSRC_DIAG_FORCE];
      end
   end

   // Filter register: high-pass always taken, data rate only in standby
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hpf_q <= 3'h0;
         odr_q <= 4'h0;
      end else if (soft_rst_q) begin
         hpf_q <= 3'h0;
         odr_q <= 4'h0;
      end else if (wr && lnk.addr == `PSRC_REG_FILTER) begin
         hpf_q <= lnk.wdata[`PSRC_FILT_HPF_LSB +: 3];
         if (standby_q) begin
            odr_q <= lnk.wdata[`PSRC_FILT_ODR_LSB +: 4];
         end
      end
   end

   // Read mux; reserved bits and write-only register read zero
   always_comb begin
      rd_d = 8'h00;
      case (lnk.addr)
         `PSRC_REG_POWER: begin
            rd_d[`PSRC_PWR_STANDBY] = standby_q;
            rd_d[`PSRC_PWR_TEMP_OFF] = temp_off_q;
            rd_d[`PSRC_PWR_DATA_READY_OUTPUT_SUPPRESS] = data_ready_output_suppress_q;
         end
         `PSRC_REG_DIAG: begin
            rd_d[`PSRC_DIAG_MODE] = diag_mode_q;
            rd_d[`PSRC_DIAG_FORCE] = diag_force_q;
         end
         `PSRC_REG_FILTER: begin
            rd_d[`PSRC_FILT_HPF_LSB +: 3] = hpf_q;
            rd_d[`PSRC_FILT_ODR_LSB +: 4] = odr_q;
         end
         `PSRC_REG_REVISION: rd_d = REVISION;
         default: begin
            if (lnk.addr >= `PSRC_REG_SHADOW_FIRST
                  && lnk.addr <= `PSRC_REG_SHADOW_LAST) begin
               rd_d = sh_data;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 8'h00;
      end else if (take) begin
         rdata_q <= lnk.we ? 8'h00 : rd_d;
      end
   end

   // Data-ready: gated by suppress, standby and trim loading
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_ready_output_q <= 1'b0;
      end else begin
         data_ready_output_q <= sample_valid && !data_ready_output_suppress_q && !standby_q
            && !shadow_loading;
      end
   end

   // Digital clear held while in standby, so entry clears pointers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clear_q <= 1'b1;
      end else begin
         clear_q <= standby_q || soft_rst_q;
      end
   end

   assign lnk.ack = ack_q;
   assign lnk.rdata = rdata_q;
   assign data_ready_output = data_ready_output_q;
   assign temp_run = !standby_q && !temp_off_q;
   assign accel_run = !standby_q;
   assign digital_clear = clear_q;
   assign diag_mode_enable = diag_mode_q;
   assign diag_force_enable = diag_force_q;
   assign hpf_setting = hpf_q;
   assign odr_setting = odr_q;
endmodule

/* File: core/psrc_params.svh */
/*
 Register offsets, field positions, reset values and timing counts
 for the power, self-test and reset control block and its controller.
 Assumes inclusion by bare name from the core/ folder.
*/
`ifndef PSRC_PARAMS_SVH
`define PSRC_PARAMS_SVH

// Device register offsets (link side)
`define PSRC_REG_REVISION 8'h01
`define PSRC_REG_FILTER 8'h28
`define PSRC_REG_POWER 8'h2d
`define PSRC_REG_DIAG 8'h2e
`define PSRC_REG_SWRST 8'h2f
`define PSRC_REG_SHADOW_FIRST 8'h50
`define PSRC_REG_SHADOW_LAST 8'h54
`define PSRC_SHADOW_COUNT 5

// Reset values and codes
`define PSRC_POWER_RST 8'h01
`define PSRC_DIAG_RST 8'h00
`define PSRC_FILTER_RST 8'h00
`define PSRC_SWRST_CODE 8'h52

// Field positions
`define PSRC_PWR_STANDBY 0
`define PSRC_PWR_TEMP_OFF 1
`define PSRC_PWR_DATA_READY_OUTPUT_SUPPRESS 2
`define PSRC_DIAG_MODE 0
`define PSRC_DIAG_FORCE 1
`define PSRC_FILT_HPF_LSB 4
`define PSRC_FILT_ODR_LSB 0

// Controller APB offsets and command fields
`define PSRC_APB_CMD 12'h000
`define PSRC_APB_STATUS 12'h004
`define PSRC_CMD_GO 0
`define PSRC_CMD_WRITE 1
`define PSRC_CMD_OP_LSB 2
`define PSRC_CMD_ADDR_LSB 8
`define PSRC_CMD_WDATA_LSB 16
`define PSRC_ST_BUSY 0
`define PSRC_ST_DONE 1
`define PSRC_ST_FAIL 2
`define PSRC_ST_TRIES_LSB 4
`define PSRC_ST_RDATA_LSB 8

// Settling time after a software reset before shadow read-back
`define PSRC_CLK_NS 10
`define PSRC_SETTLE_NS 100
`define PSRC_SETTLE_CYC ((`PSRC_SETTLE_NS + `PSRC_CLK_NS - 1) / `PSRC_CLK_NS)
`define PSRC_MAX_TRIES 8

`endif

/* File: core/psrc_pkg.sv */
/*
 Types shared by both ends of the power, self-test and reset block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package psrc_pkg;
   typedef enum logic [1:0] {
      PSRC_OP_SINGLE = 2'h0,
      PSRC_OP_CAPTURE = 2'h1,
      PSRC_OP_VERIFY = 2'h2
   } psrc_op_e;

   typedef enum logic [1:0] {
      PSRC_H_IDLE = 2'h0,
      PSRC_H_REQ = 2'h1,
      PSRC_H_WAIT = 2'h3
   } psrc_host_state_e;

   typedef enum logic {
      PSRC_L_IDLE = 1'b0,
      PSRC_L_LOAD = 1'b1
   } psrc_load_state_e;
endpackage

/* File: core/psrc_if.sv */
/*
 Register link between the controller and the sensor control block.
 Assumes both ends share pclk; a request is held until acknowledged.
*/
`timescale 1ns/1ps
interface psrc_if (
   input wire logic pclk,
   input wire logic presetn
);
   logic req;
   logic we;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic ack;
   logic [7:0] rdata;

   modport dev (
      input req,
      input we,
      input addr,
      input wdata,
      output ack,
      output rdata
   );

   modport host (
      output req,
      output we,
      output addr,
      output wdata,
      input ack,
      input rdata
   );
endinterface

/* File: core/psrc_shadow.sv */
/*
 Shadow store for factory trim: copies the nonvolatile words into
 flip-flops after reset or on restart, one word per clock.
 Assumes the nonvolatile array answers combinationally to nvm_addr.
*/
`timescale 1ns/1ps
`include "psrc_params.svh"
module psrc_shadow #(
   parameter int COUNT = `PSRC_SHADOW_COUNT
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic restart,
   output logic [2:0] nvm_addr,
   input wire logic [7:0] nvm_data,
   output logic loading,
   input wire logic [2:0] rd_idx,
   output logic [7:0] rd_data
);
   psrc_pkg::psrc_load_state_e state_q;
   logic [2:0] idx_q;
   logic [7:0] mem_q [COUNT];

   // Load starts out of reset and again on every restart
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= psrc_pkg::PSRC_L_LOAD;
         idx_q <= 3'h0;
      end else if (restart) begin
         state_q <= psrc_pkg::PSRC_L_LOAD;
         idx_q <= 3'h0;
      end else begin
         case (state_q)
            psrc_pkg::PSRC_L_LOAD: begin
               if (idx_q == 3'(COUNT - 1)) begin
                  state_q <= psrc_pkg::PSRC_L_IDLE;
               end
               idx_q <= idx_q + 3'h1;
            end
            default: state_q <= psrc_pkg::PSRC_L_IDLE;
         endcase
      end
   end

   // Restart is served whole, so a soft reset never leaves a torn load
   always_ff @(posedge pclk) begin
      if (state_q == psrc_pkg::PSRC_L_LOAD && !restart) begin
         mem_q[idx_q] <= nvm_data;
      end
   end

   assign nvm_addr = idx_q;
   assign loading = (state_q == psrc_pkg::PSRC_L_LOAD);
   assign rd_data = (rd_idx < 3'(COUNT)) ? mem_q[rd_idx] : 8'h00;
endmodule

/* File: core/psrc_host.sv */
/*
 Controller end: APB slave that runs single link transfers, captures
 the factory shadow words, and performs a verified software reset.
 Assumes APB and the link share pclk.
*/
`timescale 1ns/1ps
`include "psrc_params.svh"
module psrc_host #(
   parameter int MAX_TRIES = `PSRC_MAX_TRIES,
   parameter int SETTLE = `PSRC_SETTLE_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   psrc_if.host lnk
);
   psrc_pkg::psrc_host_state_e state_q;
   psrc_pkg::psrc_op_e op_q;
   logic we_q;
   logic [7:0] addr_q;
   logic [7:0] wdata_q;
   logic [2:0] idx_q;
   logic [7:0] saved_q [`PSRC_SHADOW_COUNT];
   logic bad_q;
   logic [3:0] tries_q;
   logic done_q;
   logic fail_q;
   logic [7:0] rdata_q;
   logic [7:0] wait_q;
   logic [31:0] prdata_q;
   logic go;
   logic last;
   logic miss;

   assign go = psel && penable && pwrite && paddr == `PSRC_APB_CMD
      && pwdata[`PSRC_CMD_GO] && state_q == psrc_pkg::PSRC_H_IDLE;
   assign last = idx_q == 3'(`PSRC_SHADOW_COUNT - 1);
   assign miss = lnk.rdata != saved_q[idx_q];

   // Read data prepared in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
      end else if (psel && !penable) begin
         prdata_q <= 32'h0;
         if (paddr == `PSRC_APB_STATUS) begin
            prdata_q[`PSRC_ST_BUSY] <= state_q != psrc_pkg::PSRC_H_IDLE;
            prdata_q[`PSRC_ST_DONE] <= done_q;
            prdata_q[`PSRC_ST_FAIL] <= fail_q;
            prdata_q[`PSRC_ST_TRIES_LSB +: 4] <= tries_q;
            prdata_q[`PSRC_ST_RDATA_LSB +: 8] <= rdata_q;
         end
      end
   end

   // Shadow copies kept for comparison after each reset
   always_ff @(posedge pclk) begin
      if (state_q == psrc_pkg::PSRC_H_REQ && lnk.ack
            && op_q == psrc_pkg::PSRC_OP_CAPTURE) begin
         saved_q[idx_q] <= lnk.rdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= psrc_pkg::PSRC_H_IDLE;
         op_q <= psrc_pkg::PSRC_OP_SINGLE;
         we_q <= 1'b0;
         addr_q <= 8'h00;
         wdata_q <= 8'h00;
         idx_q <= 3'h0;
         bad_q <= 1'b0;
         tries_q <= 4'h0;
         done_q <= 1'b0;
         fail_q <= 1'b0;
         rdata_q <= 8'h00;
         wait_q <= 8'h00;
      end else begin
         case (state_q)
            psrc_pkg::PSRC_H_IDLE: begin
               if (go) begin
                  op_q <= psrc_pkg::psrc_op_e'(pwdata[`PSRC_CMD_OP_LSB +: 2]);
                  done_q <= 1'b0;
                  fail_q <= 1'b0;
                  idx_q <= 3'h0;
                  bad_q <= 1'b0;
                  tries_q <= 4'h0;
                  state_q <= psrc_pkg::PSRC_H_REQ;
                  case (pwdata[`PSRC_CMD_OP_LSB +: 2])
                     psrc_pkg::PSRC_OP_CAPTURE: begin
                        we_q <= 1'b0;
                        addr_q <= `PSRC_REG_SHADOW_FIRST;
                     end
                     psrc_pkg::PSRC_OP_VERIFY: begin
                        we_q <= 1'b1;
                        addr_q <= `PSRC_REG_SWRST;
                        wdata_q <= `PSRC_SWRST_CODE;
                     end
                     default: begin
                        we_q <= pwdata[`PSRC_CMD_WRITE];
                        addr_q <= pwdata[`PSRC_CMD_ADDR_LSB +: 8];
                        wdata_q <= pwdata[`PSRC_CMD_WDATA_LSB +: 8];
                     end
                  endcase
               end
            end
            psrc_pkg::PSRC_H_REQ: begin
               if (lnk.ack) begin
                  rdata_q <= lnk.rdata;
                  if (op_q == psrc_pkg::PSRC_OP_VERIFY && we_q) begin
                     wait_q <= 8'(SETTLE);
                     state_q <= psrc_pkg::PSRC_H_WAIT;
                  end else if (op_q == psrc_pkg::PSRC_OP_SINGLE || last) begin
                     if (op_q == psrc_pkg::PSRC_OP_VERIFY && (bad_q || miss)
                           && tries_q + 4'h1 < 4'(MAX_TRIES)) begin
                        tries_q <= tries_q + 4'h1;
                        bad_q <= 1'b0;
                        we_q <= 1'b1;
                        addr_q <= `PSRC_REG_SWRST;
                     end else begin
                        fail_q <= op_q == psrc_pkg::PSRC_OP_VERIFY
                           && (bad_q || miss);
                        done_q <= 1'b1;
                        state_q <= psrc_pkg::PSRC_H_IDLE;
                     end
                  end else begin
                     if (op_q == psrc_pkg::PSRC_OP_VERIFY && miss) begin
                        bad_q <= 1'b1;
                     end
                     idx_q <= idx_q + 3'h1;
                     addr_q <= addr_q + 8'h01;
                  end
               end
            end
            psrc_pkg::PSRC_H_WAIT: begin
               if (wait_q == 8'h00) begin
                  we_q <= 1'b0;
                  idx_q <= 3'h0;
                  addr_q <= `PSRC_REG_SHADOW_FIRST;
                  state_q <= psrc_pkg::PSRC_H_REQ;
               end else begin
                  wait_q <= wait_q - 8'h01;
               end
            end
            default: state_q <= psrc_pkg::PSRC_H_IDLE;
         endcase
      end
   end

   assign lnk.req = state_q == psrc_pkg::PSRC_H_REQ;
   assign lnk.we = we_q;
   assign lnk.addr = addr_q;
   assign lnk.wdata = wdata_q;
   assign prdata = prdata_q;
   assign pready = penable;
   assign pslverr = 1'b0;
endmodule

/* File: sim/psrc_chk.sv */
/*
 Link checker: protocol and register read-back relations on the link.
 Assumes the link signals are wired in by name beside the interface.
*/
`timescale 1ns/1ps
`include "psrc_params.svh"
module psrc_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic req,
   input wire logic we,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic ack,
   input wire logic [7:0] rdata
);
   logic [7:0] pwr_q;
   logic [7:0] diag_q;
   logic wr_ack;
   logic swrst;
   assign wr_ack = ack && we;
   assign swrst = wr_ack && addr == `PSRC_REG_SWRST &&
      wdata == `PSRC_SWRST_CODE;
   // Expected power value: reserved bits dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_q <= `PSRC_POWER_RST;
      end else if (swrst) begin
         pwr_q <= `PSRC_POWER_RST;
      end else if (wr_ack && addr == `PSRC_REG_POWER) begin
         pwr_q <= wdata & 8'h07;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         diag_q <= `PSRC_DIAG_RST;
      end else if (swrst) begin
         diag_q <= `PSRC_DIAG_RST;
      end else if (wr_ack && addr == `PSRC_REG_DIAG) begin
         diag_q <= wdata & 8'h03;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ack_pulse: assert property (ack |=> !ack)
      else $error("ack held longer than one cycle");
   a_ack_cause: assert property (ack |-> $past(req) && !$past(ack))
      else $error("ack without a taken request");
   a_req_answer: assert property (req && !ack |=> ack)
      else $error("taken request not answered next cycle");
   a_req_hold: assert property (req && !ack |=> req && $stable({we, addr}))
      else $error("request changed before answer");
   a_power_rdback: assert property (
      ack && !we && addr == `PSRC_REG_POWER |-> rdata == pwr_q)
      else $error("power read-back wrong");
   a_diag_rdback: assert property (
      ack && !we && addr == `PSRC_REG_DIAG |-> rdata == diag_q)
      else $error("diagnostic read-back wrong");
   a_swrst_wo: assert property (
      ack && !we && addr == `PSRC_REG_SWRST |-> rdata == 8'h00)
      else $error("reset register not read as zero");
   a_wr_rdata: assert property (wr_ack |-> rdata == 8'h00)
      else $error("read data not zero after write");
   c_swrst: cover property (swrst);
   c_pwr_rd: cover property (ack && !we && addr == `PSRC_REG_POWER);
   c_diag_wr: cover property (wr_ack && addr == `PSRC_REG_DIAG);
endmodule

/* File: sim/psrc_tb_top.sv */
/*
 Testbench: APB drives the controller, which drives the sensor end.
 Assumes a combinational trim array modelled here from nvm_addr.
*/
`timescale 1ns/1ps
`include "psrc_params.svh"
`define TB_CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
   $display("[ERR] %s exp %h got %h", n, e, g); err_total++; end end
module psrc_tb_top;
   localparam int TRIES = 3;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic sample_valid, nvm_flip, data_ready_output, temp_run, accel_run;
   logic digital_clear, diag_mode_enable, diag_force_enable;
   logic shadow_loading;
   logic [2:0] hpf_setting, nvm_addr;
   logic [3:0] odr_setting;
   logic [7:0] nvm_data;
   int err_total = 0;
   int total_checks = 0;
   int load_cyc = 0;
   assign nvm_data = {5'h18, nvm_addr} ^ {8{nvm_flip}};
   psrc_if u_psrc_if (.pclk(pclk), .presetn(presetn));
   psrc_dev u_psrc_dev (.pclk(pclk), .presetn(presetn), .lnk(u_psrc_if),
      .sample_valid(sample_valid), .data_ready_output(data_ready_output),
      .temp_run(temp_run), .accel_run(accel_run),
      .digital_clear(digital_clear), .diag_mode_enable(diag_mode_enable),
      .diag_force_enable(diag_force_enable), .hpf_setting(hpf_setting),
      .odr_setting(odr_setting), .shadow_loading(shadow_loading),
      .nvm_addr(nvm_addr), .nvm_data(nvm_data));
   psrc_host #(.MAX_TRIES(TRIES)) u_psrc_host (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .lnk(u_psrc_if));
   psrc_chk u_psrc_chk (.pclk(pclk), .presetn(presetn),
      .req(u_psrc_if.req), .we(u_psrc_if.we), .addr(u_psrc_if.addr),
      .wdata(u_psrc_if.wdata), .ack(u_psrc_if.ack),
      .rdata(u_psrc_if.rdata));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) if (shadow_loading === 1'b1) load_cyc++;
   task finish_test;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task fail_out(input string what);
      $display("[ERR] %s exp done got timeout", what);
      err_total++;
      finish_test();
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) fail_out("pready");
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task link(input logic w, input logic [1:0] op, input logic [7:0] a,
      input logic [7:0] d, output logic [31:0] st);
      logic [31:0] r;
      int n;
      apb(1'b1, `PSRC_APB_CMD, {8'h00, d, a, 4'h0, op, w, 1'b1}, r);
      n = 0;
      do begin
         apb(1'b0, `PSRC_APB_STATUS, 32'h0, st);
         n++;
      end while (st[1:0] !== 2'b10 && n < 300);
      if (st[1:0] !== 2'b10) fail_out("link done");
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] s;
      link(1'b1, psrc_pkg::PSRC_OP_SINGLE, a, d, s);
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      logic [31:0] s;
      link(1'b0, psrc_pkg::PSRC_OP_SINGLE, a, 8'h00, s);
      d = s[15:8];
   endtask
   task pulse;
      @(posedge pclk);
      sample_valid <= 1'b1;
      @(posedge pclk);
      sample_valid <= 1'b0;
      #1;
   endtask
   task t_reset;
      logic [7:0] d;
      `TB_CHK("accel_run", 1'b0, accel_run)
      `TB_CHK("temp_run", 1'b0, temp_run)
      `TB_CHK("clear", 1'b1, digital_clear)
      rd(`PSRC_REG_POWER, d);
      `TB_CHK("power", 8'h01, d)
      rd(`PSRC_REG_DIAG, d);
      `TB_CHK("diag", 8'h00, d)
      rd(`PSRC_REG_SWRST, d);
      `TB_CHK("swrst", 8'h00, d)
      rd(8'h7f, d);
      `TB_CHK("unmapped", 8'h00, d)
   endtask
   task t_power;
      logic [7:0] d;
      for (int v = 0; v < 8; v++) begin
         wr(`PSRC_REG_POWER, 8'hf8 | v[7:0]);
         rd(`PSRC_REG_POWER, d);
         `TB_CHK("power", v[7:0], d)
         `TB_CHK("accel_run", ~v[0], accel_run)
         `TB_CHK("temp_run", ~v[0] & ~v[1], temp_run)
         `TB_CHK("clear", v[0], digital_clear)
         pulse();
         `TB_CHK("data_ready_output", ~v[0] & ~v[2], data_ready_output)
      end
   endtask
   task t_diag;
      logic [7:0] d;
      for (int v = 0; v < 4; v++) begin
         wr(`PSRC_REG_DIAG, 8'hfc | v[7:0]);
         rd(`PSRC_REG_DIAG, d);
         `TB_CHK("diag", v[7:0], d)
         `TB_CHK("mode", v[0], diag_mode_enable)
         `TB_CHK("force", v[1], diag_force_enable)
      end
   endtask
   task t_filter;
      wr(`PSRC_REG_POWER, 8'h01);
      wr(`PSRC_REG_FILTER, 8'h12);
      `TB_CHK("hpf", 3'h1, hpf_setting)
      `TB_CHK("odr", 4'h2, odr_setting)
      wr(`PSRC_REG_POWER, 8'h00);
      wr(`PSRC_REG_FILTER, 8'h35);
      `TB_CHK("hpf", 3'h3, hpf_setting)
      `TB_CHK("odr", 4'h2, odr_setting)
   endtask
   task t_swrst;
      logic [7:0] d;
      int n0;
      wr(`PSRC_REG_POWER, 8'h04);
      wr(`PSRC_REG_SWRST, 8'h51);
      rd(`PSRC_REG_POWER, d);
      `TB_CHK("power", 8'h04, d)
      `TB_CHK("force", 1'b1, diag_force_enable)
      n0 = load_cyc;
      wr(`PSRC_REG_SWRST, 8'h52);
      rd(`PSRC_REG_POWER, d);
      `TB_CHK("power", 8'h01, d)
      `TB_CHK("mode", 1'b0, diag_mode_enable)
      `TB_CHK("hpf", 3'h0, hpf_setting)
      `TB_CHK("load", `PSRC_SHADOW_COUNT, load_cyc - n0)
   endtask
   task t_shadow;
      logic [7:0] d;
      logic [31:0] s;
      for (int k = 0; k < 5; k++) begin
         rd(8'h50 + k[7:0], d);
         `TB_CHK("shadow", {5'h18, k[2:0]}, d)
      end
      link(1'b0, psrc_pkg::PSRC_OP_CAPTURE, 8'h00, 8'h00, s);
      `TB_CHK("capture", 1'b0, s[2])
      link(1'b0, psrc_pkg::PSRC_OP_VERIFY, 8'h00, 8'h00, s);
      `TB_CHK("fail", 1'b0, s[2])
      // Tries field counts repeated resets, not the first one
      `TB_CHK("tries", 4'h0, s[7:4])
      nvm_flip <= 1'b1;
      link(1'b0, psrc_pkg::PSRC_OP_VERIFY, 8'h00, 8'h00, s);
      `TB_CHK("fail", 1'b1, s[2])
      `TB_CHK("tries", 4'(TRIES - 1), s[7:4])
      nvm_flip <= 1'b0;
   endtask
   initial begin
      int n;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      sample_valid = 1'b0;
      nvm_flip = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (shadow_loading !== 1'b0 && n < 20);
      if (shadow_loading !== 1'b0) fail_out("trim load");
      t_reset();
      t_power();
      t_diag();
      t_filter();
      t_swrst();
      t_shadow();
      finish_test();
   end
endmodule
